// ---- verilog/fpu_condition_exception_status.sv ----
`timescale 1ns/1ns

module fpu_condition_exception_status
    import fpu_status_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // coprocessor one register moves from the core
    input wire logic [REG_NUM_W-1:0] reg_num,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_r,
    output logic reg_rvalid_r,
    // compare result from the datapath
    input wire logic cmp_valid,
    input wire logic [CC_IDX_W-1:0] cmp_cc_index,
    input wire logic cmp_result,
    // arithmetic completion from the datapath
    input wire logic arith_done,
    input wire logic [CAUSE_W-1:0] arith_cause,
    // branch and conditional move test
    input wire logic cond_test,
    input wire logic [CC_IDX_W-1:0] cond_sel,
    output logic cond_taken_r,
    output logic cond_valid_r,
    // status view for the core
    output logic [FLAGS_W-1:0] sticky_flags_r,
    output logic unimpl_op_r
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [CC_COUNT-1:0] compare_condition_bits_r;
    logic [CC_COUNT-1:0] compare_condition_bits_nxt;
    logic [CAUSE_W-1:0] cause_r;
    logic [CAUSE_W-1:0] cause_nxt;
    logic [FLAGS_W-1:0] flags_r;
    logic [FLAGS_W-1:0] flags_nxt;
    logic [31:0] rdata_nxt;
    logic rvalid_nxt;
    logic [FLAGS_W-1:0] sticky_nxt;
    logic unimpl_nxt;
    logic cc_wr;
    logic exc_wr;
    logic cc_known_r;
    logic cc_known_nxt;
    logic exc_known_r;
    logic exc_known_nxt;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // assemble the condition register image, upper bits zero
    function automatic logic [31:0] cc_image(input logic [CC_COUNT-1:0] cc);
        logic [31:0] img;
        img = 32'h0000_0000;
        img[CC_LSB +: CC_COUNT] = cc;
        return img;
    endfunction

    // assemble the exception status image, unimplemented bits zero
    function automatic logic [31:0] exc_image(input logic [CAUSE_W-1:0] cause,
                                              input logic [FLAGS_W-1:0] flags);
        logic [31:0] img;
        img = 32'h0000_0000;
        img[CAUSE_LSB +: CAUSE_W] = cause;
        img[FLAGS_LSB +: FLAGS_W] = flags;
        return img;
    endfunction

    // the five accumulating causes, unimplemented operation left out
    function automatic logic [FLAGS_W-1:0] flag_part(input logic [CAUSE_W-1:0] cause);
        return cause[CAUSE_INVALID:CAUSE_INEXACT];
    endfunction

    // ------------------------------------------------------------
    // register move decode
    // ------------------------------------------------------------
    assign cc_wr = reg_wr && (reg_num == CC_REG_NUM);
    assign exc_wr = reg_wr && (reg_num == EXC_REG_NUM);

    // ------------------------------------------------------------
    // condition code next value
    // ------------------------------------------------------------
    // a compare in the same cycle as a move wins for its own bit
    always_comb begin
        compare_condition_bits_nxt = compare_condition_bits_r;
        if (cc_wr) begin
            compare_condition_bits_nxt = reg_wdata[CC_LSB +: CC_COUNT];
        end
        if (cmp_valid) begin
            compare_condition_bits_nxt[cmp_cc_index] = cmp_result;
        end
    end

    // ------------------------------------------------------------
    // cause and flag next values
    // ------------------------------------------------------------
    // completion overwrites cause; flags take the move, then or in new causes
    always_comb begin
        cause_nxt = cause_r;
        flags_nxt = flags_r;
        if (exc_wr) begin
            cause_nxt = reg_wdata[CAUSE_LSB +: CAUSE_W];
            flags_nxt = reg_wdata[FLAGS_LSB +: FLAGS_W];
        end
        if (arith_done) begin
            cause_nxt = arith_cause;
            flags_nxt = flags_nxt | flag_part(arith_cause);
        end
    end

    // held data carries no reset: contents are unknown until software loads them
    always_ff @(posedge clock) begin
        compare_condition_bits_r <= compare_condition_bits_nxt;
        cause_r <= cause_nxt;
        flags_r <= flags_nxt;
    end

    // ------------------------------------------------------------
    // loaded markers for the unreset data
    // ------------------------------------------------------------
    // each goes high once software has written its register
    always_comb begin
        cc_known_nxt = cc_known_r | cc_wr;
        exc_known_nxt = exc_known_r | exc_wr;
    end

    // cleared by reset, unlike the data they vouch for
    always_ff @(posedge clock) begin
        if (rst) begin
            cc_known_r <= 1'b0;
            exc_known_r <= 1'b0;
        end else begin
            cc_known_r <= cc_known_nxt;
            exc_known_r <= exc_known_nxt;
        end
    end

    // ------------------------------------------------------------
    // read port next values
    // ------------------------------------------------------------
    // unmapped register numbers read zero; data shows state before this cycle
    always_comb begin
        rdata_nxt = reg_rdata_r;
        rvalid_nxt = reg_rd;
        if (reg_rd) begin
            case (reg_num)
                CC_REG_NUM: begin
                    rdata_nxt = cc_image(compare_condition_bits_r);
                end
                EXC_REG_NUM: begin
                    rdata_nxt = exc_image(cause_r, flags_r);
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // status view is loaded from the next flags and cause, so it changes in the same cycle as the stored values
    always_comb begin
        sticky_nxt = flags_nxt;
        unimpl_nxt = cause_nxt[CAUSE_UNIMPL];
    end

    // read port and status view registers
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata_r <= RD_DATA_RESET;
            reg_rvalid_r <= 1'b0;
            sticky_flags_r <= '0;
            unimpl_op_r <= 1'b0;
        end else begin
            reg_rdata_r <= rdata_nxt;
            reg_rvalid_r <= rvalid_nxt;
            sticky_flags_r <= sticky_nxt;
            unimpl_op_r <= unimpl_nxt;
        end
    end

    // ------------------------------------------------------------
    // branch and conditional move decision
    // ------------------------------------------------------------
    fpu_cc_select #(
        .COUNT(CC_COUNT),
        .IDX_W(CC_IDX_W)
    ) u_cc_select (
        .clock(clock),
        .rst(rst),
        .codes(compare_condition_bits_r),
        .sel(cond_sel),
        .test_req(cond_test),
        .taken_r(cond_taken_r),
        .valid_r(cond_valid_r)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // a compare lands in its bit, then reads back through the move port
    sequence s_compare_then_read;
        cmp_valid && !reg_wr ##1 reg_rd && reg_num == CC_REG_NUM && !cmp_valid;
    endsequence

    a_compare_stores_bit: assert property (@(posedge clock) disable iff (rst)
        cmp_valid |=> compare_condition_bits_r[$past(cmp_cc_index)] == $past(cmp_result))
        else $error("compare outcome not stored in selected condition bit");

    a_compare_read_back: assert property (@(posedge clock) disable iff (rst)
        s_compare_then_read |=> reg_rvalid_r
            && reg_rdata_r[$past(cmp_cc_index, 2)] == $past(cmp_result, 2))
        else $error("compare outcome not visible on register read");

    a_cc_upper_zero: assert property (@(posedge clock) disable iff (rst)
        reg_rd && reg_num == CC_REG_NUM |=> reg_rdata_r[31:CC_COUNT] == 24'h00_0000)
        else $error("condition register upper bits not zero");

    a_exc_unused_zero: assert property (@(posedge clock) disable iff (rst)
        reg_rd && reg_num == EXC_REG_NUM |=> reg_rdata_r[31:18] == 14'h0000
            && reg_rdata_r[11:7] == 5'h00 && reg_rdata_r[1:0] == 2'h0)
        else $error("exception register unimplemented bits not zero");

    a_cause_overwrite: assert property (@(posedge clock) disable iff (rst)
        arith_done |=> cause_r == $past(arith_cause))
        else $error("cause field not overwritten on completion");

    // completion followed by a read of the exception register
    sequence s_done_then_exc_read;
        arith_done ##1 reg_rd && reg_num == EXC_REG_NUM && !arith_done && !reg_wr;
    endsequence

    a_cause_positions: assert property (@(posedge clock) disable iff (rst)
        s_done_then_exc_read |=> reg_rdata_r[17:12] == $past(arith_cause, 2)
            && reg_rdata_r[6:2] == sticky_flags_r)
        else $error("cause bits not at documented positions");

    a_flags_sticky: assert property (@(posedge clock) disable iff (rst)
        exc_known_r && !exc_wr |=> (flags_r & $past(flags_r)) == $past(flags_r))
        else $error("sticky flag lost without a software write");

    a_flags_accumulate: assert property (@(posedge clock) disable iff (rst)
        arith_done && !exc_wr |=> flags_r[4] == ($past(arith_cause[CAUSE_INVALID]) || $past(flags_r[4]))
            && flags_r[0] == ($past(arith_cause[CAUSE_INEXACT]) || $past(flags_r[0])))
        else $error("flag bit does not match its cause position");

    a_unimpl_not_sticky: assert property (@(posedge clock) disable iff (rst)
        arith_done && !exc_wr && arith_cause == 6'h20 |=> flags_r == $past(flags_r))
        else $error("unimplemented operation leaked into flags");

    a_unmapped_zero: assert property (@(posedge clock) disable iff (rst)
        reg_rd && reg_num != CC_REG_NUM && reg_num != EXC_REG_NUM |=> reg_rdata_r == 32'h0000_0000)
        else $error("unmapped register number did not read zero");

    a_sw_write_cc: assert property (@(posedge clock) disable iff (rst)
        cc_wr && !cmp_valid |=> compare_condition_bits_r == $past(reg_wdata[7:0]))
        else $error("software write to condition codes lost");

    a_sw_clear_flags: assert property (@(posedge clock) disable iff (rst)
        exc_wr && !arith_done |=> flags_r == $past(reg_wdata[6:2]) && cause_r == $past(reg_wdata[17:12]))
        else $error("software write to exception register lost");

    a_cc_hold: assert property (@(posedge clock) disable iff (rst)
        cc_known_r && !cc_wr && !cmp_valid |=> compare_condition_bits_r == $past(compare_condition_bits_r))
        else $error("condition bits changed without compare or write");

    a_exc_hold: assert property (@(posedge clock) disable iff (rst)
        exc_known_r && !exc_wr && !arith_done |=> cause_r == $past(cause_r) && flags_r == $past(flags_r))
        else $error("exception register changed without completion or write");

    a_unimpl_view: assert property (@(posedge clock) disable iff (rst)
        arith_done |=> unimpl_op_r == $past(arith_cause[CAUSE_UNIMPL]))
        else $error("unimplemented operation view does not follow cause");

    a_read_pulse: assert property (@(posedge clock) disable iff (rst)
        reg_rvalid_r == $past(reg_rd))
        else $error("read valid is not a one cycle answer to the read");

    // completion and software write to the exception register in one cycle
    sequence s_clear_meets_set;
        exc_wr && arith_done;
    endsequence

    a_set_beats_clear: assert property (@(posedge clock) disable iff (rst)
        s_clear_meets_set |=> cause_r == $past(arith_cause)
            && flags_r == ($past(reg_wdata[6:2]) | $past(arith_cause[4:0])))
        else $error("software write beat a hardware exception set");

endmodule

// ---- verilog/fpu_status_pkg.sv ----
package fpu_status_pkg;

    // ------------------------------------------------------------
    // coprocessor one register numbers
    // ------------------------------------------------------------
    localparam int REG_NUM_W = 5;
    localparam logic [4:0] CC_REG_NUM = 5'h19;     // condition codes, register 25
    localparam logic [4:0] EXC_REG_NUM = 5'h1a;    // exception status, register 26

    // ------------------------------------------------------------
    // condition code register layout
    // ------------------------------------------------------------
    localparam int CC_COUNT = 8;
    localparam int CC_IDX_W = 3;
    localparam int CC_LSB = 0;

    // ------------------------------------------------------------
    // exception status register layout
    // ------------------------------------------------------------
    localparam int CAUSE_W = 6;
    localparam int CAUSE_LSB = 12;
    localparam int FLAGS_W = 5;
    localparam int FLAGS_LSB = 2;

    // cause field bit positions within the six bit field
    localparam int CAUSE_INEXACT = 0;
    localparam int CAUSE_UNDERFLOW = 1;
    localparam int CAUSE_OVERFLOW = 2;
    localparam int CAUSE_DIV_ZERO = 3;
    localparam int CAUSE_INVALID = 4;
    localparam int CAUSE_UNIMPL = 5;

    // read value of all register bits after a reset of the read port
    localparam logic [31:0] RD_DATA_RESET = 32'h0000_0000;

endpackage

// ---- verilog/fpu_cc_select.sv ----
`timescale 1ns/1ns

// picks one condition code bit for a branch or conditional move
module fpu_cc_select
    import fpu_status_pkg::*;
#(
    parameter int COUNT = CC_COUNT,
    parameter int IDX_W = CC_IDX_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // condition code vector and select
    input wire logic [COUNT-1:0] codes,
    input wire logic [IDX_W-1:0] sel,
    input wire logic test_req,
    // registered decision
    output logic taken_r,
    output logic valid_r
);

    logic taken_nxt;
    logic valid_nxt;

    // ------------------------------------------------------------
    // decision next values
    // ------------------------------------------------------------
    // hold the last decision between tests
    always_comb begin
        taken_nxt = taken_r;
        valid_nxt = test_req;
        if (test_req) begin
            taken_nxt = codes[sel];
        end
    end

    // registers
    always_ff @(posedge clock) begin
        if (rst) begin
            taken_r <= 1'b0;
            valid_r <= 1'b0;
        end else begin
            taken_r <= taken_nxt;
            valid_r <= valid_nxt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_branch_decision: assert property (@(posedge clock) disable iff (rst)
        test_req |=> (valid_r && taken_r == $past(codes[sel])))
        else $error("branch decision does not follow selected condition bit");

endmodule

// ---- sim/core_move_model.sv ----
`timescale 1ns/1ns

// core side of the coprocessor one register moves
module core_move_model
    import fpu_status_pkg::*;
(
    // core clock
    input wire logic clock,
    // move request
    output logic [REG_NUM_W-1:0] reg_num,
    output logic reg_wr,
    output logic [31:0] reg_wdata,
    output logic reg_rd,
    // read answer
    input wire logic [31:0] reg_rdata_r,
    input wire logic reg_rvalid_r
);
    // idle cycles before each move, raised for a slow core
    int idle = 0;

    // ------------------------------------------------------------
    // idle bus
    // ------------------------------------------------------------
    initial begin
        reg_num = 5'h00;
        reg_wr = 1'b0;
        reg_wdata = 32'h0000_0000;
        reg_rd = 1'b0;
    end

    // ------------------------------------------------------------
    // moves
    // ------------------------------------------------------------
    // write one word; taken at the next rising edge
    task automatic wr(input logic [4:0] num, input logic [31:0] data);
        repeat (idle) @(negedge clock);
        @(negedge clock);
        reg_num = num;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_num = ~num;
        reg_wdata = ~data; // released bus shows no stale word
    endtask

    // read one word; answer is registered at the taking edge and sampled at the next falling edge
    task automatic rd(input logic [4:0] num, output logic [31:0] data, output logic ok);
        repeat (idle) @(negedge clock);
        @(negedge clock);
        reg_num = num;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        reg_num = ~num;
        ok = reg_rvalid_r;
        data = reg_rdata_r;
    endtask
endmodule

// ---- sim/fpu_condition_exception_status_tb.sv ----
`timescale 1ns/1ns

module fpu_condition_exception_status_tb
    import fpu_status_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [4:0] reg_num;
    logic reg_wr, reg_rd, rvalid, rok;
    logic [31:0] reg_wdata, rdata, rdat;
    logic cmp_valid = 1'b0, cmp_result = 1'b0, arith_done = 1'b0, cond_test = 1'b0;
    logic [2:0] cmp_cc_index = 3'h0, cond_sel = 3'h0;
    logic [5:0] arith_cause = 6'h00;
    logic taken, cvalid, unimpl;
    logic [4:0] flags;
    int errors = 0;
    int samples_checked = 0;
    int seed = 32'h620d;
    int cc_m, cause_m, flags_m, c;

    always #25 clock = ~clock;

    // ------------------------------------------------------------
    // design and core model
    // ------------------------------------------------------------
    fpu_condition_exception_status dut_u (.clock(clock), .rst(rst), .reg_num(reg_num), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(rdata), .reg_rvalid_r(rvalid),
        .cmp_valid(cmp_valid), .cmp_cc_index(cmp_cc_index), .cmp_result(cmp_result),
        .arith_done(arith_done), .arith_cause(arith_cause), .cond_test(cond_test), .cond_sel(cond_sel),
        .cond_taken_r(taken), .cond_valid_r(cvalid), .sticky_flags_r(flags), .unimpl_op_r(unimpl));
    core_move_model core_u (.clock(clock), .reg_num(reg_num), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata_r(rdata), .reg_rvalid_r(rvalid));

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input int exp);
        samples_checked++;
        if (seen !== 32'(exp)) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, 32'(exp), seen);
        end
    endtask

    task automatic rdchk(input logic [4:0] num, input int exp);
        core_u.rd(num, rdat, rok);
        check("rvalid", {31'h0, rok}, 1);
        check("rdata", rdat, exp);
    endtask

    function automatic int exc_word();
        return (cause_m << 12) | (flags_m << 2);
    endfunction

    task automatic cmp(input int idx, input int res);
        @(negedge clock);
        cmp_valid = 1'b1;
        cmp_cc_index = idx[2:0];
        cmp_result = res[0];
        @(negedge clock);
        cmp_valid = 1'b0;
        cmp_result = ~res[0];
        cc_m = res[0] ? (cc_m | (1 << idx)) : (cc_m & ~(1 << idx));
    endtask

    task automatic test(input int sel);
        @(negedge clock);
        cond_test = 1'b1;
        cond_sel = sel[2:0];
        @(negedge clock);
        cond_test = 1'b0;
        check("cond_valid", {31'h0, cvalid}, 1);
        check("cond_taken", {31'h0, taken}, (cc_m >> sel) & 1);
    endtask

    // one completion pulse from the datapath
    task automatic done_pulse(input int cv);
        @(negedge clock);
        arith_done = 1'b1;
        arith_cause = cv[5:0];
        @(negedge clock);
        arith_done = 1'b0;
    endtask

    // completion with a read of the exception register one cycle plus the core's idle cycles behind it
    task automatic arith(input int cv);
        fork
            done_pulse(cv);
            begin
                @(negedge clock);
                core_u.rd(EXC_REG_NUM, rdat, rok);
            end
        join
        cause_m = cv & 63;
        flags_m = flags_m | (cv & 31);
        check("sticky", {27'h0, flags}, flags_m);
        check("unimpl", {31'h0, unimpl}, (cv >> 5) & 1);
        check("exc_rvalid", {31'h0, rok}, 1);
        check("exc_rdata", rdat, exc_word());
    endtask

    // completion and a software clear in one cycle: the hardware set wins
    task automatic clash(input int cv);
        fork
            core_u.wr(EXC_REG_NUM, 32'h0000_0000);
            done_pulse(cv);
        join
        cause_m = cv & 63;
        flags_m = cv & 31;
        rdchk(EXC_REG_NUM, exc_word());
        check("clash_sticky", {27'h0, flags}, flags_m);
    endtask

    task automatic close_out();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        #(3000 * 50);
        errors++;
        close_out();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clock);
        rst = 1'b0;
        cc_m = $random(seed) & 255;
        core_u.wr(CC_REG_NUM, cc_m | 32'hffff_ff00);
        core_u.wr(EXC_REG_NUM, 32'h0000_0000);
        cause_m = 0;
        flags_m = 0;
        rdchk(CC_REG_NUM, cc_m);
        core_u.wr(EXC_REG_NUM, 32'hffff_ffff);
        rdchk(EXC_REG_NUM, 32'h0003_f07c);
        core_u.wr(EXC_REG_NUM, 32'h0000_0000);
        rdchk(EXC_REG_NUM, 0);
        core_u.wr(5'h1b, 32'hffff_ffff);
        rdchk(5'h1b, 0);
        rdchk(CC_REG_NUM, cc_m);
        // compares into random bits, then every select
        for (int i = 0; i < 24; i++) begin
            cmp($random(seed) & 7, $random(seed) & 1);
        end
        for (int s = 0; s < 8; s++) begin
            test(s);
        end
        rdchk(CC_REG_NUM, cc_m);
        // a compare read back in the very next cycle
        for (int i = 0; i < 4; i++) begin
            fork
                cmp($random(seed) & 7, $random(seed) & 1);
                begin
                    @(negedge clock);
                    core_u.rd(CC_REG_NUM, rdat, rok);
                end
            join
            check("next_rvalid", {31'h0, rok}, 1);
            check("next_cc", rdat, cc_m);
        end
        // each cause alone, then random ones with a slow core
        for (int k = 0; k < 6; k++) begin
            arith(1 << k);
        end
        // software clear meeting a completion
        clash(($random(seed) & 63) | 1);
        core_u.idle = 2;
        for (int i = 0; i < 8; i++) begin
            c = $random(seed) & 63;
            arith(c);
        end
        // mid-run reset: every output falls to zero
        @(negedge clock);
        rst = 1'b1;
        @(negedge clock);
        check("reset_rdata", rdata, 0);
        check("reset_outs", {23'h0, rvalid, taken, cvalid, flags, unimpl}, 0);
        repeat (4) @(negedge clock);
        rst = 1'b0;
        core_u.wr(EXC_REG_NUM, 32'h0000_0000);
        cause_m = 0;
        flags_m = 0;
        rdchk(EXC_REG_NUM, 0);
        close_out();
    end
endmodule
